// ---- adc_control.sv ----
`timescale 1ns/1ns
// Summary of operation
// [R1] Inputs k and k+4 share result register k
// [R2] Control/status clears on reset and standby
// [R3] End flag: single end or scan pass
// [R4] Flag clears on write 0 after read-1
// [R5] Transfer controller service clears end flag
// [R6] Interrupt request equals enable and flag
// [R7] Converter runs only while start bit set
// [R8] Single mode: one conversion, start self-clears
// [R9] Scan mode repeats until start cleared
// [R10] Bit 4 selects single or scan mode
// [R11] Bit 3 selects 274 or 138 states
// [R12] Group bit plus index select channels
// [R13] Software changes channel/speed only when halted
// [R14] Trigger register resets to 7f, standby too
// [R15] Trigger enable gates falling-edge pin start
// [R16] Trigger bits 6..0 read one, ignore writes
// [R17] Upper byte read copies lower to latch
// [R18] Lower byte read returns the latch
// [R19] Software reads upper before lower byte
// [R20] Upper-byte-only reads need no latch
// [R21] Result left-aligned, low bits 5..0 zero
// [R22] Results clear on reset and standby
// [R23] Result registers ignore bus writes
module adc_control (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              standby,
	input  adc_pkg::bus_req_s      bus,
	input  wire logic              dtc_service,
	input  wire logic              external_trigger_pin,
	input  wire logic              core_done,
	input  wire logic [9:0]        core_result,
	output logic      [15:0]       rdata,
	output logic                   rvalid,
	output adc_pkg::conv_req_s     core_req,
	output logic                   conversion_end_interrupt
);

	// -----------------------------------------------------------------
	// Register state
	// -----------------------------------------------------------------
	logic                          end_flag_q;
	logic                          end_flag_d;
	logic                          flag_seen_q;
	logic                          end_interrupt_enable_q;
	logic                          start_q;
	logic                          start_d;
	logic                          scan_q;
	logic                          speed_select_q;
	logic [2:0]                    channel_q;
	logic                          trigger_enable_q;
	logic                          pin_q;
	logic [1:0]                    index_q;
	logic [1:0]                    index_d;
	logic                          running_q;
	logic [7:0]                    temp_q;
	logic                          rd_pend_q;
	logic [15:0]                   rd_addr_q;
	logic                          rd_word_q;
	adc_pkg::conv_state_e          state_q;
	adc_pkg::conv_state_e          state_d;

	// -----------------------------------------------------------------
	// Address decode
	// -----------------------------------------------------------------
	logic                          clr_all;
	logic                          csr_wr;
	logic                          trg_wr;
	logic                          csr_rd;
	logic                          res_rd;
	logic [1:0]                    res_idx;
	logic [7:0]                    csr_value;
	logic [7:0]                    trg_value;
	logic                          trig_fall;
	logic                          conv_start;
	logic                          conv_end;
	logic                          last_channel;
	logic                          timer_done;
	logic [9:0]                    store_rd;
	logic [7:0]                    live_low;
	logic                          trg_rd;
	logic                          timer_start;
	logic                          store_wr;
	logic                          upper_rd;

	assign clr_all   = !nrst || standby;                                   // [R2] [R14] [R22]
	assign csr_wr    = bus.wr && (bus.addr == adc_pkg::control_status_addr);
	assign trg_wr    = bus.wr && (bus.addr == adc_pkg::trigger_control_addr);
	assign csr_rd    = bus.rd && (bus.addr == adc_pkg::control_status_addr);
	assign res_rd    = bus.rd && (bus.addr >= adc_pkg::result_a_high_addr)
	                          && (bus.addr <= adc_pkg::result_d_low_addr);
	// Result window: bits 2..1 pick the register, bit 0 the byte
	assign res_idx   = bus.addr[2:1];
	assign csr_value = {end_flag_q, end_interrupt_enable_q, start_q, scan_q,
	                    speed_select_q, channel_q};
	assign trg_value = {trigger_enable_q, adc_pkg::trigger_reserved_ones}; // [R16]
	assign trg_rd    = bus.rd && (bus.addr == adc_pkg::trigger_control_addr);

	// -----------------------------------------------------------------
	// Start sources and conversion sequencing
	// -----------------------------------------------------------------
	// Pin is synchronous; a registered copy gives the falling edge
	assign trig_fall    = trigger_enable_q && pin_q && !external_trigger_pin;       // [R15]
	assign last_channel = !scan_q || (index_q == channel_q[1:0]);
	assign conv_end     = (state_q == adc_pkg::conv_busy) && timer_done;
	assign conv_start   = start_q && !running_q;                                    // [R7]
	// Timer reloads on every entry to busy, so each scan step is paced afresh
	assign timer_start  = (state_d == adc_pkg::conv_busy) && (state_q != adc_pkg::conv_busy);
	// The core answer is stored only if it is ready when the budget runs out
	assign store_wr     = conv_end && core_done;

	// Start bit: written, triggered, or self-cleared at a single end
	// A trigger edge wins over a write of zero in the same cycle
	always_comb begin
		start_d = start_q;
		if (csr_wr) begin
			start_d = bus.wdata[adc_pkg::start_bit];                            // [R7]
		end
		if (conv_end && !scan_q) begin
			start_d = 1'b0;                                                     // [R8]
		end
		if (trig_fall) begin
			start_d = 1'b1;                                                     // [R15]
		end
	end

	// Channel sequencer: scan walks 0..k of the group, single holds k
	always_comb begin
		state_d = state_q;
		index_d = index_q;
		case (state_q)
		adc_pkg::conv_idle: begin
			if (conv_start) begin
				state_d = adc_pkg::conv_busy;
				index_d = scan_q ? 2'b00 : channel_q[1:0];                  // [R12]
			end
		end
		adc_pkg::conv_busy: begin
			if (!start_q) begin
				state_d = adc_pkg::conv_idle;                               // [R7]
			end else if (timer_done) begin
				state_d = adc_pkg::conv_done;
			end
		end
		adc_pkg::conv_done: begin
			if (scan_q && start_q) begin
				state_d = adc_pkg::conv_busy;                               // [R9]
				index_d = last_channel ? 2'b00 : index_q + 2'b01;
			end else begin
				state_d = adc_pkg::conv_idle;
			end
		end
		default: state_d = adc_pkg::conv_idle;
		endcase
	end

	// End flag: set wins over any clear in the same cycle
	// A read of the set flag arms the write-0 clear; a service needs no arming
	always_comb begin
		end_flag_d = end_flag_q;
		if (csr_wr && flag_seen_q && !bus.wdata[adc_pkg::end_flag_bit]) begin
			end_flag_d = 1'b0;                                                  // [R4]
		end
		if (dtc_service) begin
			end_flag_d = 1'b0;                                                  // [R5]
		end
		if (conv_end && last_channel) begin
			end_flag_d = 1'b1;                                                  // [R3]
		end
	end

	// -----------------------------------------------------------------
	// Control/status and trigger registers
	// -----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (clr_all) begin
			end_flag_q             <= adc_pkg::control_status_reset[7];         // [R2]
			flag_seen_q            <= 1'b0;
			end_interrupt_enable_q <= adc_pkg::control_status_reset[6];
			start_q                <= adc_pkg::control_status_reset[5];
			scan_q                 <= adc_pkg::control_status_reset[4];
			speed_select_q         <= adc_pkg::control_status_reset[3];
			channel_q              <= adc_pkg::control_status_reset[2:0];
		end else begin
			end_flag_q <= end_flag_d;
			start_q    <= start_d;
			// A read of a set flag arms the later clear
			if (csr_rd && end_flag_q) begin
				flag_seen_q <= 1'b1;
			end else if (csr_wr || !end_flag_q) begin
				flag_seen_q <= 1'b0;
			end
			if (csr_wr) begin
				end_interrupt_enable_q <= bus.wdata[adc_pkg::int_enable_bit];
				scan_q                 <= bus.wdata[adc_pkg::scan_bit];     // [R10]
				speed_select_q         <= bus.wdata[adc_pkg::speed_bit];    // [R11]
				channel_q              <= bus.wdata[adc_pkg::group_bit:0];  // [R12]
			end
		end
	end

	// Trigger enable; reserved bits hold no storage at all
	// The pin copy leaves reset high, so a pin idle high at reset release never looks like an edge
	always_ff @(posedge clk) begin
		if (clr_all) begin
			trigger_enable_q <= adc_pkg::trigger_control_reset[7];              // [R14]
			pin_q            <= 1'b1;
		end else begin
			pin_q <= external_trigger_pin;
			if (trg_wr) begin
				trigger_enable_q <= bus.wdata[adc_pkg::trigger_enable_bit];
			end
		end
	end

	// Sequencer state
	// The running flag follows the next state, so conv_start lasts one cycle
	always_ff @(posedge clk) begin
		if (clr_all) begin
			state_q   <= adc_pkg::conv_idle;
			index_q   <= 2'b00;
			running_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			index_q   <= index_d;
			running_q <= (state_d != adc_pkg::conv_idle);
		end
	end

	// -----------------------------------------------------------------
	// Conversion timing and result storage
	// -----------------------------------------------------------------
	conv_timer u_timer (
		.clk   (clk),
		.nrst  (!clr_all),
		.start (timer_start),
		.abort (!start_q),
		.fast  (speed_select_q),                                                // [R11]
		.done  (timer_done)
	);

	// Channel k and k+4 land in register k; writes from the bus never reach here
	result_store u_store (
		.clk     (clk),
		.nrst    (!clr_all),                                                    // [R22]
		.wr_en   (store_wr),
		.wr_idx  (index_q),                                                     // [R1]
		.wr_data (core_result),
		.rd_idx  (res_idx),
		.rd_data (store_rd)
	);                                                                              // [R23]

	// -----------------------------------------------------------------
	// Read path: one cycle behind the store, with temp latch
	// -----------------------------------------------------------------
	assign live_low = {store_rd[1:0], 6'h00};                                      // [R21]
	// Upper byte or word read: the low byte moves to the latch at the same time
	// A low byte read first returns whatever the latch last held
	assign upper_rd = rd_pend_q && (rd_word_q || !rd_addr_q[0]);

	always_ff @(posedge clk) begin
		if (clr_all) begin
			rd_pend_q <= 1'b0;
			rd_addr_q <= 16'h0000;
			rd_word_q <= 1'b0;
		end else begin
			rd_pend_q <= res_rd;
			rd_addr_q <= bus.addr;
			rd_word_q <= bus.word;
		end
	end

	// Outputs: registers answer at once, results one cycle later
	always_ff @(posedge clk) begin
		if (clr_all) begin
			rdata                    <= 16'h0000;
			rvalid                   <= 1'b0;
			temp_q                   <= 8'h00;
			core_req                 <= '0;
			conversion_end_interrupt <= 1'b0;
		end else begin
			core_req.go              <= conv_start;
			core_req.channel         <= {channel_q[2], index_d};                // [R12]
			conversion_end_interrupt <= end_interrupt_enable_q && end_flag_d;   // [R6]
			rvalid                   <= rd_pend_q || (bus.rd && !res_rd);
			if (upper_rd) begin
				temp_q <= live_low;                                         // [R17]
				rdata  <= rd_word_q ? {store_rd[9:2], live_low}
				                    : {8'h00, store_rd[9:2]};               // [R21]
			end else if (rd_pend_q) begin
				rdata <= {8'h00, temp_q};                                   // [R18]
			end else if (csr_rd) begin
				rdata <= {8'h00, csr_value};
			end else if (trg_rd) begin
				rdata <= {8'h00, trg_value};                                // [R16]
			end else if (bus.rd) begin
				rdata <= 16'h0000;
			end
		end
	end

endmodule // adc_control

// ---- adc_pkg.sv ----
package adc_pkg;

	// -----------------------------------------------------------------
	// Register map (byte addresses on the internal bus)
	// -----------------------------------------------------------------
	localparam logic [15:0] result_a_high_addr     = 16'hfee0;
	localparam logic [15:0] result_d_low_addr      = 16'hfee7;
	localparam logic [15:0] control_status_addr    = 16'hfee8;
	localparam logic [15:0] trigger_control_addr   = 16'hfee9;

	// -----------------------------------------------------------------
	// Field positions and reset values
	// -----------------------------------------------------------------
	localparam int          end_flag_bit           = 7;
	localparam int          int_enable_bit         = 6;
	localparam int          start_bit              = 5;
	localparam int          scan_bit               = 4;
	localparam int          speed_bit              = 3;
	localparam int          group_bit              = 2;
	localparam int          trigger_enable_bit     = 7;
	localparam logic [7:0]  control_status_reset   = 8'h00;
	localparam logic [7:0]  trigger_control_reset  = 8'h7f;
	localparam logic [6:0]  trigger_reserved_ones  = 7'h7f;
	localparam logic [9:0]  result_reset           = 10'h000;

	// -----------------------------------------------------------------
	// Conversion times in states (one state is one clk cycle)
	// -----------------------------------------------------------------
	localparam logic [8:0]  slow_conv_states       = 9'd274;
	localparam logic [8:0]  fast_conv_states       = 9'd138;

	// Bus request from the processor core or transfer controller
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic        word;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} bus_req_s;

	// Request to the analog core: start pulse and channel
	typedef struct packed {
		logic       go;
		logic [2:0] channel;
	} conv_req_s;

	typedef enum logic [1:0] {
		conv_idle,
		conv_busy,
		conv_done
	} conv_state_e;

endpackage

// ---- conv_timer.sv ----
`timescale 1ns/1ns
// Paces one conversion: counts the state budget, then fires a done pulse
module conv_timer (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              start,
	input  wire logic              abort,
	input  wire logic              fast,
	output logic                   done
);

	logic [8:0]                    count_q;
	logic [8:0]                    count_d;
	logic                          run_q;
	logic                          run_d;
	logic                          last;

	// -----------------------------------------------------------------
	// Count down from the selected budget
	// -----------------------------------------------------------------
	assign last    = run_q && (count_q == 9'h001);
	assign run_d   = abort ? 1'b0 : (start ? 1'b1 : (last ? 1'b0 : run_q));
	assign count_d = start ? (fast ? adc_pkg::fast_conv_states : adc_pkg::slow_conv_states)
	                       : (run_q ? count_q - 9'h001 : count_q);

	// State registers
	always_ff @(posedge clk) begin
		if (!nrst) begin
			count_q <= 9'h000;
			run_q   <= 1'b0;
			done    <= 1'b0;
		end else begin
			count_q <= count_d;
			run_q   <= run_d;
			done    <= last && !abort && !start;
		end
	end

endmodule // conv_timer

// ---- result_store.sv ----
`timescale 1ns/1ns
// Four 10-bit result registers with a registered read port
module result_store (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic              wr_en,
	input  wire logic [1:0]        wr_idx,
	input  wire logic [9:0]        wr_data,
	input  wire logic [1:0]        rd_idx,
	output logic      [9:0]        rd_data
);

	logic [9:0]                    mem_q [4];

	// Writes come only from the conversion side; the bus cannot reach them
	always_ff @(posedge clk) begin
		if (!nrst) begin
			for (int i = 0; i < 4; i++) begin
				mem_q[i] <= adc_pkg::result_reset;
			end
			rd_data <= adc_pkg::result_reset;
		end else begin
			if (wr_en) begin
				mem_q[wr_idx] <= wr_data;
			end
			rd_data <= mem_q[rd_idx];
		end
	end

endmodule // result_store

// ---- adc_control_properties.sv ----
`timescale 1ns/1ns
module adc_control_properties (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  wire logic          standby,
	input  adc_pkg::bus_req_s  bus,
	input  wire logic          dtc_service,
	input  wire logic          external_trigger_pin,
	input  wire logic          core_done,
	input  wire logic [9:0]    core_result,
	input  wire logic [15:0]   rdata,
	input  wire logic          rvalid,
	input  adc_pkg::conv_req_s core_req,
	input  wire logic          conversion_end_interrupt
);
	// ------------------------------
	// Address decode of bus requests
	// ------------------------------
	wire res_rd = bus.rd && bus.addr[15:3] == 13'h1fdc;
	wire ctl_rd = bus.rd && bus.addr == adc_pkg::control_status_addr;
	wire trg_rd = bus.rd && bus.addr == adc_pkg::trigger_control_addr;
	wire irq    = conversion_end_interrupt;

	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	// Standby clears like reset, so outputs fall quiet at once
	chk_standby_quiets: assert property (standby |=> !rvalid && !core_req.go && !irq)
		else $error("outputs active after standby");
	chk_trigger_ones: assert property (trg_rd |=> rvalid && rdata[6:0] == 7'h7f)
		else $error("trigger reserved bits not one");
	chk_status_answer: assert property (ctl_rd |=> rvalid)
		else $error("status read not answered");
	// Result reads pass through the store, one extra cycle; a low byte or word has zero bits 5..0, an upper byte a zero high byte
	chk_result_timing: assert property (res_rd |=> !rvalid ##1 (rvalid
		&& (($past(bus.word, 2) || $past(bus.addr[0], 2)) ? rdata[5:0] == 6'h00 : rdata[15:8] == 8'h00)))
		else $error("result read timing or padding wrong");
	chk_unmapped_zero: assert property (bus.rd && !res_rd && !ctl_rd && !trg_rd |=> rvalid && rdata == 16'h0000)
		else $error("unmapped read not zero");
	chk_write_silent: assert property (bus.wr && !bus.rd |=> !rvalid)
		else $error("write produced read data");
	chk_go_pulse: assert property (core_req.go |=> !core_req.go)
		else $error("start request longer than a pulse");
	// Only a write, a service or standby may take the request away
	chk_irq_holds: assert property (irq && !dtc_service && !$past(dtc_service) && !bus.wr
		&& !$past(bus.wr) && !standby |=> irq)
		else $error("interrupt dropped without cause");
	chk_service_drop: assert property (dtc_service && !core_req.go |-> ##[1:2] !irq)
		else $error("service did not clear interrupt");
endmodule // adc_control_properties

bind adc_control adc_control_properties chk (.clk(clk), .nrst(nrst), .standby(standby), .bus(bus),
	.dtc_service(dtc_service), .external_trigger_pin(external_trigger_pin), .core_done(core_done),
	.core_result(core_result), .rdata(rdata), .rvalid(rvalid), .core_req(core_req),
	.conversion_end_interrupt(conversion_end_interrupt));

// ---- analog_core_model.sv ----
`timescale 1ns/1ns
// Analog core stand-in: answers a conversion a set number of cycles after go
module analog_core_model #(
	parameter int delay = 2
) (
	input  wire logic          clk,
	input  wire logic          nrst,
	input  adc_pkg::conv_req_s core_req,
	output logic               core_done,
	output logic [9:0]         core_result
);
	int count_q;
	wire [9:0] val = {core_req.channel, ~core_req.channel, core_req.channel, 1'b1};

	// Not ready shows the inverse, so stale data never passes as valid
	assign core_done   = count_q >= delay;
	assign core_result = core_done ? val : ~val;

	// Delay counter restarts at each go
	always_ff @(posedge clk) begin
		if (!nrst)
			count_q <= 0;
		else if (core_req.go)
			count_q <= 1;
		else if (count_q != 0 && count_q < delay)
			count_q <= count_q + 1;
	end
endmodule // analog_core_model

// ---- test_adc_control_and_result_access.sv ----
`timescale 1ns/1ns
module test_adc_control_and_result_access;
	logic               clk = 1'b0;
	logic               nrst = 1'b0;
	logic               standby = 1'b0;
	logic               dtc_service = 1'b0;
	logic               trigger_pin_n = 1'b1;
	adc_pkg::bus_req_s  bus = '0;
	logic               core_done;
	logic [9:0]         core_result;
	logic [15:0]        rdata;
	logic               rvalid;
	adc_pkg::conv_req_s core_req;
	logic               irq;
	int                 errors = 0;
	int                 cmp_count = 0;
	int                 n, cyc, lim;
	logic [15:0]        v;
	logic [9:0]         cv;
	logic [2:0]         ch;
	logic               ie, fast;
	localparam logic [15:0] ctl = adc_pkg::control_status_addr;
	localparam logic [15:0] trg = adc_pkg::trigger_control_addr;
	localparam logic [15:0] ra  = adc_pkg::result_a_high_addr;

	always #4 clk = ~clk;

	adc_control uut (.clk(clk), .nrst(nrst), .standby(standby), .bus(bus), .dtc_service(dtc_service),
		.external_trigger_pin(trigger_pin_n), .core_done(core_done), .core_result(core_result),
		.rdata(rdata), .rvalid(rvalid), .core_req(core_req), .conversion_end_interrupt(irq));
	analog_core_model #(.delay(3)) core (.clk(clk), .nrst(nrst), .core_req(core_req),
		.core_done(core_done), .core_result(core_result));

	// ------------------
	// Expectation, bus and checks
	// ------------------
	function automatic logic [9:0] conv_val(input logic [2:0] c);
		return {c, ~c, c, 1'b1};
	endfunction

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		bus.wr = 1'b1;
		bus.addr = a;
		bus.wdata = d;
		@(negedge clk);
		bus.wr = 1'b0;
	endtask

	// Reads are spaced by the answer, so two result reads never abut
	task automatic rd(input logic [15:0] a, input logic w, output logic [15:0] d);
		int i;
		@(negedge clk);
		bus.rd = 1'b1;
		bus.word = w;
		bus.addr = a;
		@(negedge clk);
		bus.rd = 1'b0;
		for (i = 0; i < 4 && rvalid !== 1'b1; i++)
			@(negedge clk);
		d = (rvalid === 1'b1) ? rdata : 16'hxxxx;
	endtask

	task automatic wait_flag();
		time t0;
		int i;
		t0 = $time;
		v = 16'h0000;
		for (i = 0; i < 400 && v[7] !== 1'b1; i++)
			rd(ctl, 1'b0, v);
		cyc = int'(($time - t0) / 8);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog sized well above the whole sequence
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		$display("ERROR watchdog expected finish seen hang");
		results();
	end

	// ------------------
	// Main sequence
	// ------------------
	initial begin
		void'($urandom(32'h14a1696f));
		repeat (3) @(negedge clk);
		nrst = 1'b1;
		wr(ra, 8'hff);
		wr(trg, 8'h00);
		rd(ctl, 1'b0, v);
		check("status reset", 16'h0000, {8'h00, v[7:0]});
		rd(trg, 1'b0, v);
		check("trigger ones", 16'h007f, {8'h00, v[7:0]});
		for (n = 0; n < 4; n++) begin
			rd(ra + 16'(2 * n), 1'b1, v);
			check("result reset", 16'h0000, v);
		end
		rd(16'hfeea, 1'b0, v);
		check("unmapped", 16'h0000, v);
		wr(trg, 8'h80);
		wr(ctl, 8'h4f);
		rd(trg, 1'b0, v);
		check("trigger set", 16'h00ff, {8'h00, v[7:0]});
		@(negedge clk);
		standby = 1'b1;
		@(negedge clk);
		standby = 1'b0;
		rd(trg, 1'b0, v);
		check("trigger standby", 16'h007f, {8'h00, v[7:0]});
		rd(ctl, 1'b0, v);
		check("status standby", 16'h0000, {8'h00, v[7:0]});
		// Single conversions on random channels, both speeds
		for (n = 0; n < 8; n++) begin
			ch = 3'($urandom);
			ie = (n != 3);
			fast = n[0];
			wr(ctl, {1'b0, ie, 2'b10, fast, ch});
			wait_flag();
			lim = int'(fast ? adc_pkg::fast_conv_states : adc_pkg::slow_conv_states);
			check("conv time", 16'h0001, 16'(cyc >= lim - 20 && cyc <= lim + 8));
			check("status end", 16'({1'b1, ie, 2'b00, fast, ch}), {8'h00, v[7:0]});
			check("irq", 16'(ie), 16'(irq));
			cv = conv_val(ch);
			rd(ra + 16'(2 * ch[1:0]), 1'b0, v);
			check("upper", 16'(cv[9:2]), {8'h00, v[7:0]});
			rd(ra + 16'(2 * 2'(ch[1:0] + 2'd1) + 1), 1'b0, v);
			check("low latch", {8'h00, cv[1:0], 6'h00}, {8'h00, v[7:0]});
			rd(ra + 16'(2 * ch[1:0]), 1'b1, v);
			check("word", {cv, 6'h00}, v);
			wr(ctl, {1'b1, ie, 2'b00, fast, ch});
			rd(ctl, 1'b0, v);
			check("flag kept", 16'h0001, 16'(v[7]));
			if (n[0]) begin
				@(negedge clk);
				dtc_service = 1'b1;
				@(negedge clk);
				dtc_service = 1'b0;
			end else
				wr(ctl, {1'b0, ie, 2'b00, fast, ch});
			rd(ctl, 1'b0, v);
			check("flag cleared", 16'h0000, 16'(v[7]));
			check("irq cleared", 16'h0000, 16'(irq));
		end
		// Scan pass over a random group and width
		ch = 3'($urandom);
		wr(ctl, {5'b01111, ch});
		wait_flag();
		check("scan running", 16'h0001, 16'(v[5]));
		for (n = 0; n <= int'(ch[1:0]); n++) begin
			rd(ra + 16'(2 * n), 1'b1, v);
			cv = conv_val({ch[2], 2'(n)});
			check("scan result", {cv, 6'h00}, v);
		end
		wr(ctl, 8'h00);
		repeat (300) @(negedge clk);
		rd(ctl, 1'b0, v);
		check("scan halted", 16'h0000, {8'h00, v[7:0]});
		// Trigger pin ignored, then honoured
		wr(trg, 8'h00);
		wr(ctl, 8'h48);
		trigger_pin_n = 1'b0;
		repeat (4) @(negedge clk);
		rd(ctl, 1'b0, v);
		check("no trigger", 16'h0048, {8'h00, v[7:0]});
		trigger_pin_n = 1'b1;
		wr(trg, 8'h80);
		trigger_pin_n = 1'b0;
		wait_flag();
		check("trigger end", 16'h00c8, {8'h00, v[7:0]});
		trigger_pin_n = 1'b1;
		results();
	end
endmodule // test_adc_control_and_result_access
